// [hw/gim_params.svh]
// Offsets, field positions, reset values and timing counts of the pin interrupt block
`ifndef GIM_PARAMS_SVH
`define GIM_PARAMS_SVH

`define GIM_ADDR_SYS_STS 32'h0000_0058
`define GIM_ADDR_SYS_EN 32'h0000_005C
`define GIM_ADDR_IND_CFG 32'h0000_01BC
`define GIM_ADDR_PIN_CFG 32'h0000_01E0
`define GIM_ADDR_PIN_IRQ 32'h0000_01E8

`define GIM_PIN_EN_LSB 16
`define GIM_PIN_POL_LSB 16
`define GIM_FUN_LSB 8
`define GIM_FUN_W 2
`define GIM_FUN_COUNT 4
`define GIM_SYS_LOAD_BIT 0
`define GIM_SYS_GPIO_BIT 12

`define GIM_PIN_EN_RST 12'h000
`define GIM_PIN_STS_RST 12'h000
`define GIM_PIN_CFG_RST 12'h000
`define GIM_IND_SEL_RST 8'h00
`define GIM_IND_FUN_RST 2'h0
`define GIM_SYS_EN_RST 13'h0000

`define GIM_CLK_NS 50
`define GIM_SRC_MIN_NS 40
`define GIM_SRC_MIN_CYC ((`GIM_SRC_MIN_NS + `GIM_CLK_NS - 1) / `GIM_CLK_NS)
`define GIM_STRAP_SETTLE 2'h3

`endif

// [hw/gim_pkg.sv]
// Types shared by the pin interrupt and indicator block
package gim_pkg;
   typedef enum logic [1:0] {
      GIM_STRAP_WAIT = 2'b00,
      GIM_STRAP_LATCH = 2'b01,
      GIM_STRAP_RUN = 2'b10
   } gim_strap_state_t;
endpackage

// [hw/gim_pin_sync.sv]
// Three-stage input synchroniser; output follows once stages two and three agree
module gim_pin_sync #(
   parameter int WIDTH = 12
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_dout;
   logic [WIDTH-1:0] agree;

   if (WIDTH < 1) begin : g_chk
      $error("gim_pin_sync: WIDTH must be at least 1");
   end

   always_comb begin
      agree = ~(stage2 ^ stage3);
      next_dout = (dout & ~agree) | (stage3 & agree);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         dout <= '0;
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         dout <= next_dout;
      end
   end
endmodule

// [hw/gim_top.sv]
// Pin interrupt status/enable, system summary and indicator pin selection with AHB-Lite access
//
// The implementer's own choice: the AHB-Lite slave port.
`include "gim_params.svh"
module gim_top #(
   parameter int PIN_COUNT = 12,
   parameter int LED_COUNT = 8
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [PIN_COUNT-1:0] pinIn,
   input wire logic [PIN_COUNT-1:0] pinIsOutput,
   input wire logic [LED_COUNT-1:0] gpioOut,
   input wire logic [LED_COUNT-1:0] gpioOe,
   input wire logic [`GIM_FUN_COUNT-1:0][LED_COUNT-1:0] indicatorSource,
   input wire logic [LED_COUNT-1:0] indicatorSelectStrap,
   input wire logic [`GIM_FUN_W-1:0] indicatorFunctionStrap,
   input wire logic loaderWrite,
   input wire logic [LED_COUNT-1:0] loaderSelect,
   input wire logic [`GIM_FUN_W-1:0] loaderFunction,
   output logic [LED_COUNT-1:0] pinOut,
   output logic [LED_COUNT-1:0] pinOe,
   output logic irqOut
);
   localparam int STRAP_W = LED_COUNT + `GIM_FUN_W;
   localparam logic [12:0] SYS_EN_RST = `GIM_SYS_EN_RST;

   if (PIN_COUNT < 1 || PIN_COUNT > 12 || LED_COUNT < 1 || LED_COUNT > 8
       || LED_COUNT > PIN_COUNT || `GIM_SRC_MIN_CYC > 1) begin : g_chk
      $error("gim_top: unsupported PIN_COUNT or LED_COUNT");
   end

   // Bus slave state
   logic wrPend;
   logic [31:0] wrAddr;
   logic next_wrPend;
   logic [31:0] next_wrAddr;
   logic [31:0] next_hrdata;
   logic accept;

   // Register state
   logic [PIN_COUNT-1:0] pinStatus;
   logic [PIN_COUNT-1:0] pinEnable;
   logic [PIN_COUNT-1:0] pinIrqCapable;
   logic [PIN_COUNT-1:0] pinPolarity;
   logic [LED_COUNT-1:0] indSelect;
   logic [`GIM_FUN_W-1:0] indFunction;
   logic sysGpioEn;
   logic sysLoadEn;
   logic sysLoadSts;
   logic [PIN_COUNT-1:0] next_pinStatus;
   logic [PIN_COUNT-1:0] next_pinEnable;
   logic [PIN_COUNT-1:0] next_pinIrqCapable;
   logic [PIN_COUNT-1:0] next_pinPolarity;
   logic [LED_COUNT-1:0] next_indSelect;
   logic [`GIM_FUN_W-1:0] next_indFunction;
   logic next_sysGpioEn;
   logic next_sysLoadEn;
   logic next_sysLoadSts;
   logic next_irqOut;

   // Strap latch state
   gim_pkg::gim_strap_state_t strapState;
   gim_pkg::gim_strap_state_t next_strapState;
   logic [1:0] settleCnt;
   logic [1:0] next_settleCnt;

   // Derived signals
   logic [PIN_COUNT-1:0] pinSync;
   logic [STRAP_W-1:0] strapSync;
   logic [PIN_COUNT-1:0] ledRole;
   logic [PIN_COUNT-1:0] pinSource;
   logic [PIN_COUNT-1:0] pinClear;
   logic gpioSummary;
   logic wrIndCfg;
   logic wrPinIrq;
   logic wrPinCfg;
   logic wrSysSts;
   logic wrSysEn;
   logic [LED_COUNT-1:0] next_pinOut;
   logic [LED_COUNT-1:0] next_pinOe;
   logic [LED_COUNT-1:0] funcSignal;

   gim_pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .din(pinIn),
      .dout(pinSync)
   );

   gim_pin_sync #(.WIDTH(STRAP_W)) u_strap_sync (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .din({indicatorFunctionStrap, indicatorSelectStrap}),
      .dout(strapSync)
   );

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign accept = hsel & htrans[1] & hready;

   always_comb begin
      wrIndCfg = wrPend && (wrAddr == `GIM_ADDR_IND_CFG);
      wrPinIrq = wrPend && (wrAddr == `GIM_ADDR_PIN_IRQ);
      wrPinCfg = wrPend && (wrAddr == `GIM_ADDR_PIN_CFG);
      wrSysSts = wrPend && (wrAddr == `GIM_ADDR_SYS_STS);
      wrSysEn = wrPend && (wrAddr == `GIM_ADDR_SYS_EN);
      ledRole = '0;
      ledRole[LED_COUNT-1:0] = indSelect;
      // An indicator pin or a driven pin is no interrupt input
      pinSource = pinIrqCapable & ~pinIsOutput & ~ledRole & ~(pinSync ^ pinPolarity);
      pinClear = wrPinIrq ? hwdata[PIN_COUNT-1:0] : '0;
      gpioSummary = |(pinStatus & pinEnable);
   end

   // Register file next values; hardware set wins over a same-cycle clear
   always_comb begin
      next_pinStatus = (pinStatus & ~pinClear) | pinSource;
      next_pinEnable = pinEnable;
      next_pinIrqCapable = pinIrqCapable;
      next_pinPolarity = pinPolarity;
      next_indSelect = indSelect;
      next_indFunction = indFunction;
      next_sysGpioEn = sysGpioEn;
      next_sysLoadEn = sysLoadEn;
      next_sysLoadSts = sysLoadSts;
      if (wrPinIrq) begin
         next_pinEnable = hwdata[`GIM_PIN_EN_LSB +: PIN_COUNT];
      end
      if (wrPinCfg) begin
         next_pinIrqCapable = hwdata[PIN_COUNT-1:0];
         next_pinPolarity = hwdata[`GIM_PIN_POL_LSB +: PIN_COUNT];
      end
      if (wrSysEn) begin
         next_sysGpioEn = hwdata[`GIM_SYS_GPIO_BIT];
         next_sysLoadEn = hwdata[`GIM_SYS_LOAD_BIT];
      end
      if (wrSysSts && hwdata[`GIM_SYS_LOAD_BIT]) begin
         next_sysLoadSts = 1'b0;
      end
      if (wrIndCfg) begin
         next_indSelect = hwdata[LED_COUNT-1:0];
         next_indFunction = hwdata[`GIM_FUN_LSB +: `GIM_FUN_W];
      end
      if (loaderWrite) begin
         next_indSelect = loaderSelect;
         next_indFunction = loaderFunction;
         next_sysLoadSts = 1'b1;
      end
      if (strapState == gim_pkg::GIM_STRAP_LATCH) begin
         next_indSelect = strapSync[LED_COUNT-1:0];
         next_indFunction = strapSync[LED_COUNT +: `GIM_FUN_W];
      end
      next_irqOut = (gpioSummary & sysGpioEn) | (sysLoadSts & sysLoadEn);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinStatus <= `GIM_PIN_STS_RST;
         pinEnable <= `GIM_PIN_EN_RST;
         pinIrqCapable <= `GIM_PIN_CFG_RST;
         pinPolarity <= `GIM_PIN_CFG_RST;
         indSelect <= `GIM_IND_SEL_RST;
         indFunction <= `GIM_IND_FUN_RST;
         sysGpioEn <= SYS_EN_RST[`GIM_SYS_GPIO_BIT];
         sysLoadEn <= SYS_EN_RST[`GIM_SYS_LOAD_BIT];
         sysLoadSts <= 1'b0;
         irqOut <= 1'b0;
      end else begin
         pinStatus <= next_pinStatus;
         pinEnable <= next_pinEnable;
         pinIrqCapable <= next_pinIrqCapable;
         pinPolarity <= next_pinPolarity;
         indSelect <= next_indSelect;
         indFunction <= next_indFunction;
         sysGpioEn <= next_sysGpioEn;
         sysLoadEn <= next_sysLoadEn;
         sysLoadSts <= next_sysLoadSts;
         irqOut <= next_irqOut;
      end
   end

   // Straps are caught once the synchronisers have filled after reset release
   always_comb begin
      next_strapState = strapState;
      next_settleCnt = settleCnt;
      case (strapState)
         gim_pkg::GIM_STRAP_WAIT: begin
            next_settleCnt = settleCnt + 2'h1;
            if (settleCnt == `GIM_STRAP_SETTLE) begin
               next_strapState = gim_pkg::GIM_STRAP_LATCH;
            end
         end
         gim_pkg::GIM_STRAP_LATCH: begin
            next_strapState = gim_pkg::GIM_STRAP_RUN;
         end
         gim_pkg::GIM_STRAP_RUN: begin
            next_strapState = gim_pkg::GIM_STRAP_RUN;
         end
         default: begin
            next_strapState = gim_pkg::GIM_STRAP_WAIT;
            next_settleCnt = 2'h0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         strapState <= gim_pkg::GIM_STRAP_WAIT;
         settleCnt <= 2'h0;
      end else begin
         strapState <= next_strapState;
         settleCnt <= next_settleCnt;
      end
   end

   // Bus slave: zero wait states, read data registered in the address phase
   always_comb begin
      next_wrPend = accept & hwrite;
      next_wrAddr = accept ? haddr : wrAddr;
      next_hrdata = 32'h0000_0000;
      if (accept && !hwrite) begin
         case (haddr)
            `GIM_ADDR_PIN_IRQ: begin
               next_hrdata[PIN_COUNT-1:0] = next_pinStatus;
               next_hrdata[`GIM_PIN_EN_LSB +: PIN_COUNT] = next_pinEnable;
            end
            `GIM_ADDR_PIN_CFG: begin
               next_hrdata[PIN_COUNT-1:0] = next_pinIrqCapable;
               next_hrdata[`GIM_PIN_POL_LSB +: PIN_COUNT] = next_pinPolarity;
            end
            `GIM_ADDR_IND_CFG: begin
               next_hrdata[LED_COUNT-1:0] = next_indSelect;
               next_hrdata[`GIM_FUN_LSB +: `GIM_FUN_W] = next_indFunction;
            end
            `GIM_ADDR_SYS_STS: begin
               next_hrdata[`GIM_SYS_GPIO_BIT] = |(next_pinStatus & next_pinEnable);
               next_hrdata[`GIM_SYS_LOAD_BIT] = next_sysLoadSts;
            end
            `GIM_ADDR_SYS_EN: begin
               next_hrdata[`GIM_SYS_GPIO_BIT] = next_sysGpioEn;
               next_hrdata[`GIM_SYS_LOAD_BIT] = next_sysLoadEn;
            end
            default: begin
               next_hrdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPend <= 1'b0;
         wrAddr <= 32'h0000_0000;
         hrdata <= 32'h0000_0000;
      end else begin
         wrPend <= next_wrPend;
         wrAddr <= next_wrAddr;
         hrdata <= next_hrdata;
      end
   end

   // Indicator pin multiplexer
   for (genvar i = 0; i < LED_COUNT; i++) begin : g_led
      always_comb begin
         funcSignal[i] = indicatorSource[indFunction][i];
         next_pinOut[i] = indSelect[i] ? funcSignal[i] : gpioOut[i];
         next_pinOe[i] = indSelect[i] | gpioOe[i];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinOut <= '0;
         pinOe <= '0;
      end else begin
         pinOut <= next_pinOut;
         pinOe <= next_pinOe;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_clear_write;
      wrPinIrq ##0 (pinSource == '0);
   endsequence

   w1c_clear_a: assert property (s_clear_write |=>
      ((pinStatus & $past(hwdata[PIN_COUNT-1:0])) == '0))
      else $error("written status bit not cleared");
   summary_or_a: assert property ((|(pinStatus & pinEnable)) && sysGpioEn |=> irqOut)
      else $error("enabled pin status did not raise interrupt");
   irq_cause_a: assert property (irqOut |->
      $past(((|(pinStatus & pinEnable)) && sysGpioEn) || (sysLoadSts && sysLoadEn)))
      else $error("interrupt without enabled cause");
   enable_hold_a: assert property (!wrPinIrq |=> $stable(pinEnable))
      else $error("pin enable changed without write");
   status_track_a: assert property (pinSource != '0 |=>
      ((pinStatus & $past(pinSource)) == $past(pinSource)))
      else $error("active source not captured");
   irq_gate_a: assert property (!sysGpioEn && !sysLoadEn |=> !irqOut)
      else $error("interrupt without system enable");
   pin_role_a: assert property (((pinOe ^ $past(gpioOe)) & ~$past(indSelect)) == '0
      && (($past(indSelect) & ~pinOe) == '0))
      else $error("pin role wrong");
   func_apply_a: assert property (((pinOut ^ $past(gpioOut)) & ~$past(indSelect)) == '0
      && ((pinOut ^ $past(indicatorSource[indFunction])) & $past(indSelect)) == '0)
      else $error("indicator function not applied");
   strap_latch_a: assert property (strapState == gim_pkg::GIM_STRAP_LATCH |=>
      {indFunction, indSelect} == $past(strapSync))
      else $error("straps not latched");
   loader_set_a: assert property (loaderWrite && strapState != gim_pkg::GIM_STRAP_LATCH |=>
      indSelect == $past(loaderSelect) && indFunction == $past(loaderFunction) && sysLoadSts)
      else $error("loader override lost");
   sticky_hold_a: assert property ((pinStatus & ~pinClear) != '0 |=>
      ((pinStatus & $past(pinStatus & ~pinClear)) == $past(pinStatus & ~pinClear)))
      else $error("status bit dropped without clear");
endmodule

// [test/gim_pin_source.sv]
// External pin source model driving the GPIO input levels
module gim_pin_source (
   input wire logic sysClk,
   output logic [11:0] pinLevel
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pinLevel = 12'h000;
   // Raise one pin for some clocks, then return it to its inactive low level
   task automatic pulse(input int pin, input int cycles);
      @(posedge sysClk);
      pinLevel[pin] <= 1'h1;
      repeat (cycles) @(posedge sysClk);
      pinLevel[pin] <= 1'h0;
   endtask
endmodule

// [test/gpio_irq_and_indicator_mux_bench.sv]
// Self-checking bench for the pin interrupt and indicator block
`include "gim_params.svh"
module gpio_irq_and_indicator_mux_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic sysClk, arstN, hsel, hwrite, hreadyout, hresp, irqOut, loaderWrite;
   logic [31:0] haddr, hwdata, hrdata, src, rd;
   logic [1:0] htrans, strapFun, loaderFunction, fun;
   logic [2:0] hsize;
   logic [11:0] pinIn, pinIsOutput;
   logic [7:0] gpioOut, gpioOe, strapSel, loaderSelect, pinOut, pinOe, sel;
   int seed, fail_count, checks, k, pin;
   gim_top gim_top_i (.sys_clk(sysClk), .arst_n(arstN), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pinIn(pinIn),
      .pinIsOutput(pinIsOutput), .gpioOut(gpioOut), .gpioOe(gpioOe), .indicatorSource(src),
      .indicatorSelectStrap(strapSel), .indicatorFunctionStrap(strapFun),
      .loaderWrite(loaderWrite), .loaderSelect(loaderSelect),
      .loaderFunction(loaderFunction), .pinOut(pinOut), .pinOe(pinOe), .irqOut(irqOut));
   gim_pin_source gim_pin_source_i (.sysClk(sysClk), .pinLevel(pinIn));
   initial begin
      sysClk = 1'h0;
      forever #25 sysClk = ~sysClk;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Values are taken in the settled half cycle before the edge that completes the phase
   task automatic phaseWait(output logic [31:0] r);
      int n;
      logic rdy;
      n = 0;
      do begin
         @(negedge sysClk);
         r = hrdata;
         rdy = hreadyout;
         @(posedge sysClk);
         n++;
      end while (rdy !== 1'h1 && n < 20);
      if (rdy !== 1'h1) begin
         fail_count++;
         $display("unexpected at %0t: bus wait ran out", $time);
         final_report();
      end
   endtask
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      phaseWait(rd);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      phaseWait(rd);
   endtask
   task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'h0, 32'h0);
      chk(rd, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic irqChk(input logic exp);
      repeat (2) @(posedge sysClk);
      @(negedge sysClk);
      chk({31'h0, irqOut}, {31'h0, exp});
      @(posedge sysClk);
   endtask
   function automatic logic [7:0] expOut(input logic [7:0] s, input logic [1:0] f,
         input logic [31:0] v, input logic [7:0] g);
      for (int i = 0; i < 8; i++) expOut[i] = s[i] ? v[f * 8 + i] : g[i];
   endfunction
   initial begin
      repeat (20000) @(posedge sysClk);
      fail_count++;
      $display("unexpected at %0t: run limit reached", $time);
      final_report();
   end
   initial begin
      seed = 33806;
      fail_count = 0;
      checks = 0;
      arstN = 1'h0;
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      pinIsOutput = 12'h000;
      loaderWrite = 1'h0;
      loaderSelect = 8'h00;
      loaderFunction = 2'h0;
      strapSel = 8'($random(seed));
      strapFun = 2'($random(seed));
      gpioOut = 8'h00;
      gpioOe = 8'h00;
      src = 32'h0;
      repeat (4) @(posedge sysClk);
      arstN <= 1'h1;
      repeat (8) @(posedge sysClk);
      rdChk(`GIM_ADDR_IND_CFG, {22'h0, strapFun, strapSel});
      rdChk(`GIM_ADDR_PIN_IRQ, 32'h0);
      bus(32'h0000_0100, 1'h1, 32'hFFFF_FFFF);
      rdChk(32'h0000_0100, 32'h0);
      // Every function code with a mixed selection of indicator pins
      for (k = 0; k < 4; k++) begin
         sel = 8'($random(seed));
         gpioOut <= 8'($random(seed));
         gpioOe <= 8'($random(seed));
         src <= $random(seed);
         bus(`GIM_ADDR_IND_CFG, 1'h1, {22'h0, k[1:0], sel});
         repeat (2) @(posedge sysClk);
         @(negedge sysClk);
         chk({24'h0, pinOut}, {24'h0, expOut(sel, k[1:0], src, gpioOut)});
         chk({24'h0, pinOe}, {24'h0, sel | gpioOe});
         @(posedge sysClk);
      end
      sel = 8'($random(seed));
      fun = 2'($random(seed));
      loaderSelect <= sel;
      loaderFunction <= fun;
      loaderWrite <= 1'h1;
      @(posedge sysClk);
      loaderWrite <= 1'h0;
      @(posedge sysClk);
      rdChk(`GIM_ADDR_IND_CFG, {22'h0, fun, sel});
      rdChk(`GIM_ADDR_SYS_STS, 32'h1);
      bus(`GIM_ADDR_SYS_STS, 1'h1, 32'h1);
      bus(`GIM_ADDR_IND_CFG, 1'h1, 32'h0);
      bus(`GIM_ADDR_PIN_CFG, 1'h1, 32'h0FFF_0FFF);
      // Pin events: sticky set, summary, top-level gate, write-one clear
      for (k = 0; k < 4; k++) begin
         pin = (k == 0) ? 11 : {$random(seed)} % 12;
         gim_pin_source_i.pulse(pin, 4);
         repeat (6) @(posedge sysClk);
         rdChk(`GIM_ADDR_PIN_IRQ, 32'h1 << pin);
         irqChk(1'h0);
         bus(`GIM_ADDR_PIN_IRQ, 1'h1, 32'h1 << (pin + 16));
         rdChk(`GIM_ADDR_SYS_STS, 32'h1000);
         irqChk(1'h0);
         bus(`GIM_ADDR_SYS_EN, 1'h1, 32'h1000);
         irqChk(1'h1);
         rdChk(`GIM_ADDR_PIN_IRQ, (32'h1 << pin) | (32'h1 << (pin + 16)));
         bus(`GIM_ADDR_PIN_IRQ, 1'h1, 32'h1 << pin);
         rdChk(`GIM_ADDR_PIN_IRQ, 32'h0);
         irqChk(1'h0);
         bus(`GIM_ADDR_SYS_EN, 1'h1, 32'h0);
      end
      // Active-low pin 1 at idle level: set at once and re-set after a clear
      bus(`GIM_ADDR_PIN_CFG, 1'h1, 32'h0000_0002);
      rdChk(`GIM_ADDR_PIN_IRQ, 32'h2);
      bus(`GIM_ADDR_PIN_IRQ, 1'h1, 32'h2);
      rdChk(`GIM_ADDR_PIN_IRQ, 32'h2);
      // Indicator pins and output pins raise no status
      bus(`GIM_ADDR_IND_CFG, 1'h1, 32'h0000_0002);
      bus(`GIM_ADDR_PIN_IRQ, 1'h1, 32'h2);
      rdChk(`GIM_ADDR_PIN_IRQ, 32'h0);
      pinIsOutput <= 12'h002;
      bus(`GIM_ADDR_IND_CFG, 1'h1, 32'h0);
      rdChk(`GIM_ADDR_PIN_IRQ, 32'h0);
      final_report();
   end
endmodule
